// ---- ssd_byte_lane.v ----
// One packed byte lane: left shift with overflow, arithmetic right shift
`timescale 1ns/1ps
module ssd_byte_lane #(
  parameter W = 8,
  parameter CW = 3
) (
  // Lane operand and count
  input wire [W-1:0] lane_in,
  input wire [CW-1:0] cnt,
  input wire round_en,
  // Results
  output wire [W-1:0] left_out,
  output wire left_ovf,
  output wire [W-1:0] right_out
);

  wire [2*W-1:0] left_wide;
  wire signed [W+1:0] ext;
  wire signed [W+1:0] shr;
  wire [W+1:0] rnd;

  // Zero-extended left shift; a set bit pushed out or landing on top flags
  assign left_wide = {{W{1'b0}}, lane_in} << cnt; // see (RL2)
  assign left_out = left_wide[W-1:0];
  // Count zero must never flag, though the top bit is then in view
  assign left_ovf = (cnt != {CW{1'b0}}) &&
    (|left_wide[2*W-1:W-1]); // see (RL5) (RL22)

  // Extra low guard bit holds the top discarded bit for rounding
  assign ext = {lane_in[W-1], lane_in, 1'b0};
  assign shr = ext >>> cnt; // see (RL17)
  assign rnd = shr + {{(W+1){1'b0}}, 1'b1}; // see (RL19)
  // Count zero leaves the lane as is: the guard bit is zero there
  assign right_out = round_en ? rnd[W:1] : shr[W:1]; // see (RL22)

endmodule

// ---- ssd_chk.sv ----
// Port checker for the packed shift datapath
`timescale 1ns/1ps
`include "ssd_defs.vh"
module ssd_chk (
  input wire CLK,
  input wire RESET,
  input wire INSTR_VALID,
  input wire [31:0] INSTR,
  input wire [63:0] SRC_VAL,
  input wire [63:0] OPND_VAL,
  input wire EXT_ENABLE,
  input wire OVF_CLEAR,
  input wire RESULT_VALID,
  input wire [63:0] RESULT,
  input wire EXC_RESERVED,
  input wire EXC_DISABLED,
  input wire OVF_SET,
  input wire OVF_FLAG,
  input wire [3:0] LANE_OVF
);
  // Decode of the five shift operations
  wire [4:0] sb = INSTR[10:6];
  wire rgt = sb[4:1] == 4'h2;
  wire ok = INSTR_VALID && INSTR[31:26] == `SSD_MAJOR_GROUP &&
    INSTR[5:0] == `SSD_SHIFT_FUNC && (rgt || sb == `SSD_SUB_VLB ||
    sb == `SSD_SUB_VLWC || sb == `SSD_SUB_ILWC);
  wire rsv = ok && rgt && INSTR[25:24] != 2'h0;
  wire ans = RESULT_VALID || EXC_RESERVED || EXC_DISABLED;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_take; ok; endsequence
  sequence s_ans; ans; endsequence
  answer_latency_a: assert property (s_take |=> s_ans)
    else $error("no answer one cycle after issue");
  foreign_silent_a: assert property (!ok |=> !ans)
    else $error("answer to an undecoded word");
  reserved_bits_a: assert property (rsv |=> EXC_RESERVED && !RESULT_VALID)
    else $error("reserved right shift not refused");
  disabled_exc_a: assert property (ok && !rsv && !EXT_ENABLE |=>
    EXC_DISABLED && !OVF_SET && !RESULT_VALID)
    else $error("disabled extension not refused");
  sign_extend_a: assert property (RESULT_VALID |->
    RESULT[63:32] == {32{RESULT[31]}})
    else $error("upper word not sign extended");
  flag_sticky_a: assert property (OVF_SET |-> OVF_FLAG)
    else $error("overflow flag not set");
  flag_only_clear_a: assert property ($fell(OVF_FLAG) |->
    $past(OVF_CLEAR) && !OVF_SET)
    else $error("overflow flag dropped without clear");
  zero_count_a: assert property (ok && !rsv && EXT_ENABLE &&
    sb == `SSD_SUB_VLB && SRC_VAL[2:0] == 3'h0 |=> !OVF_SET &&
    RESULT[31:0] == $past(OPND_VAL[31:0]) && LANE_OVF == 4'h0)
    else $error("zero count changed the bytes");
  lane_flag_a: assert property (|LANE_OVF |-> OVF_SET && RESULT_VALID)
    else $error("lane overflow without flag set");
endmodule
bind ssd_shift_datapath ssd_chk ssd_chk_i (.CLK, .RESET, .INSTR_VALID,
  .INSTR, .SRC_VAL, .OPND_VAL, .EXT_ENABLE, .OVF_CLEAR, .RESULT_VALID,
  .RESULT, .EXC_RESERVED, .EXC_DISABLED, .OVF_SET, .OVF_FLAG, .LANE_OVF);

// ---- ssd_core_model.sv ----
// Register file writeback model on the datapath's result side
`timescale 1ns/1ps
module ssd_core_model (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Result from the datapath
  input wire res_valid,
  input wire [63:0] res,
  // Last destination write
  output reg [63:0] wb_r
);
  // One write per committed result; exceptions write nothing
  always @(posedge clk) begin
    if (reset) wb_r <= 64'h0;
    else if (res_valid) wb_r <= res;
  end
endmodule

// ---- ssd_defs.vh ----
// Constants for the packed shift datapath: encodings, fields and limits
`ifndef SSD_DEFS_VH
`define SSD_DEFS_VH

// Instruction field positions
`define SSD_MAJOR_HI 31
`define SSD_MAJOR_LO 26
`define SSD_FUNC_HI 5
`define SSD_FUNC_LO 0
`define SSD_SUBOP_HI 10
`define SSD_SUBOP_LO 6
`define SSD_AMT5_HI 25
`define SSD_AMT5_LO 21
`define SSD_AMT3_HI 23
`define SSD_AMT3_LO 21
`define SSD_RSVD_HI 25
`define SSD_RSVD_LO 24

// Opcode values
`define SSD_MAJOR_GROUP 6'h1F
`define SSD_SHIFT_FUNC 6'h13
`define SSD_SUB_VLB 5'h02
`define SSD_SUB_VLWC 5'h16
`define SSD_SUB_ILWC 5'h14
`define SSD_SUB_ARB 5'h04
`define SSD_SUB_ARBR 5'h05

// Saturation limits of a 32-bit word
`define SSD_WORD_MAX 32'h7FFFFFFF
`define SSD_WORD_MIN 32'h80000000

// Overflow flag position in the extension control register
`define SSD_OVF_BIT 22

// Reset values
`define SSD_RST_RESULT 64'h0000000000000000
`define SSD_RST_LANES 4'h0

`endif

// ---- ssd_shift_datapath.v ----
// Packed shift datapath of the signal-processing extension, top level
//
// Function
// (RL1) Decode variable byte left shift: major 011111, function 010011, sub 00010.
// (RL2) Shift each low byte left alone, zero fill, same lane out.
// (RL3) Byte left count is source register bits 2..0, unsigned.
// (RL4) Packed-byte results copy top byte sign into upper 32 bits.
// (RL5) Any byte lane overflow sets overflow flag bit 22.
// (RL6) Decode variable word clamp shift: sub-operation 10110.
// (RL7) Word left shift zero fill, clamp by unshifted sign on overflow.
// (RL8) Variable word count is source register bits 4..0, unsigned.
// (RL9) Both word clamp shifts sign-extend the 32-bit result to 64.
// (RL10) Variable word clamp overflow sets overflow flag bit 22.
// (RL11) Decode immediate word clamp shift: sub 10100, count bits 25..21.
// (RL12) Clamp to 0x7FFFFFFF if non-negative, 0x80000000 if negative.
// (RL13) Overflow when shifted-out bits and new top bit are mixed.
// (RL14) Immediate word clamp overflow sets overflow flag bit 22.
// (RL15) Immediate word clamp raises reserved or extension-disabled exception; here it raises only extension-disabled, never reserved.
// (RL16) Decode byte right shift 00100, rounding 00101; bits 25..24 zero.
// (RL17) Arithmetic right shift per byte, each lane's own sign fill.
// (RL18) Right shift count is a three-bit unsigned immediate, 0 to 7.
// (RL19) Rounding form adds 1 at top discarded bit before truncating.
// (RL20) No exception ever depends on operand values.
// (RL21) Overflow flag is only set here, cleared solely by software.
// (RL22) Count zero passes elements unchanged, no clamp, no flag.
`timescale 1ns/1ps
`include "ssd_defs.vh"
module ssd_shift_datapath #(
  parameter HAS_REV2 = 1
) (
  // Clock and reset
  input wire CLK,
  input wire RESET,
  // Issue from the pipeline
  input wire INSTR_VALID,
  input wire [31:0] INSTR,
  input wire [63:0] SRC_VAL,
  input wire [63:0] OPND_VAL,
  input wire EXT_ENABLE,
  // Software write clearing the overflow flag
  input wire OVF_CLEAR,
  // Result back to the register file
  output reg RESULT_VALID,
  output reg [63:0] RESULT,
  // Exceptions
  output reg EXC_RESERVED,
  output reg EXC_DISABLED,
  // Overflow reporting
  output reg OVF_SET,
  output reg OVF_FLAG,
  output reg [3:0] LANE_OVF
);

  //////////////////////////////////////////////////////////////////////////
  // Opcode classes
  localparam OP_NONE = 3'h0;
  localparam OP_VLB = 3'h1;
  localparam OP_VLWC = 3'h2;
  localparam OP_ILWC = 3'h3;
  localparam OP_ARB = 3'h4;
  localparam OP_ARBR = 3'h5;

  wire [5:0] major;
  wire [5:0] func;
  wire [4:0] subop;
  wire [1:0] rsvd;
  wire group_hit;
  reg [2:0] op_cls;
  reg rsvd_bad;

  assign major = INSTR[`SSD_MAJOR_HI:`SSD_MAJOR_LO];
  assign func = INSTR[`SSD_FUNC_HI:`SSD_FUNC_LO];
  assign subop = INSTR[`SSD_SUBOP_HI:`SSD_SUBOP_LO];
  assign rsvd = INSTR[`SSD_RSVD_HI:`SSD_RSVD_LO];
  assign group_hit = (major == `SSD_MAJOR_GROUP) &&
    (func == `SSD_SHIFT_FUNC);

  // Classify; other sub-operations belong to sibling units, left alone
  always @* begin
    op_cls = OP_NONE;
    rsvd_bad = 1'b0;
    if (group_hit) begin
      case (subop)
        `SSD_SUB_VLB: op_cls = OP_VLB; // see (RL1)
        `SSD_SUB_VLWC: op_cls = OP_VLWC; // see (RL6)
        `SSD_SUB_ILWC: op_cls = OP_ILWC; // see (RL11)
        `SSD_SUB_ARB: begin
          op_cls = OP_ARB; // see (RL16)
          rsvd_bad = (rsvd != 2'h0) || (HAS_REV2 == 0);
        end
        `SSD_SUB_ARBR: begin
          op_cls = OP_ARBR; // see (RL16)
          rsvd_bad = (rsvd != 2'h0) || (HAS_REV2 == 0);
        end
        default: op_cls = OP_NONE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Shift counts; higher source bits are simply never looked at
  wire [2:0] byte_left_cnt;
  wire [2:0] byte_right_cnt;
  wire [4:0] word_cnt;
  wire is_round;

  assign byte_left_cnt = SRC_VAL[2:0]; // see (RL3)
  assign byte_right_cnt = INSTR[`SSD_AMT3_HI:`SSD_AMT3_LO]; // see (RL18)
  assign word_cnt = (op_cls == OP_ILWC) ?
    INSTR[`SSD_AMT5_HI:`SSD_AMT5_LO] : SRC_VAL[4:0]; // see (RL8) (RL11)
  assign is_round = (op_cls == OP_ARBR);

  // Four identical lanes share one count
  wire [31:0] left_bytes;
  wire [31:0] right_bytes;
  wire [3:0] lane_ovf;
  wire [2:0] lane_cnt;

  assign lane_cnt = (op_cls == OP_VLB) ? byte_left_cnt : byte_right_cnt;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      ssd_byte_lane #(
        .W(8),
        .CW(3)
      ) u_lane (
        .lane_in(OPND_VAL[8*g+7:8*g]),
        .cnt(lane_cnt),
        .round_en(is_round),
        .left_out(left_bytes[8*g+7:8*g]),
        .left_ovf(lane_ovf[g]),
        .right_out(right_bytes[8*g+7:8*g])
      );
    end
  endgenerate

  // Word clamp unit serves both the variable and immediate forms
  wire [31:0] word_res;
  wire word_ovf;

  ssd_word_clamp #(
    .W(32),
    .CW(5)
  ) u_word (
    .word_in(OPND_VAL[31:0]),
    .cnt(word_cnt),
    .word_out(word_res),
    .word_ovf(word_ovf)
  );

  //////////////////////////////////////////////////////////////////////////
  // Result selection and exception screening
  reg [63:0] result_nxt;
  reg ovf_nxt;
  reg [3:0] lanes_nxt;
  reg ours;
  reg exc_rsvd_nxt;
  reg exc_dis_nxt;

  always @* begin
    result_nxt = `SSD_RST_RESULT;
    ovf_nxt = 1'b0;
    lanes_nxt = `SSD_RST_LANES;
    ours = INSTR_VALID && (op_cls != OP_NONE);
    // Screening looks only at encoding and enable, never at data
    exc_rsvd_nxt = ours && rsvd_bad; // see (RL15) (RL20)
    exc_dis_nxt = ours && !rsvd_bad && !EXT_ENABLE; // see (RL15)
    case (op_cls)
      OP_VLB: begin
        result_nxt = {{32{left_bytes[31]}}, left_bytes}; // see (RL4)
        lanes_nxt = lane_ovf;
        ovf_nxt = |lane_ovf; // see (RL5) (RL22)
      end
      OP_VLWC: begin
        result_nxt = {{32{word_res[31]}}, word_res}; // see (RL9)
        ovf_nxt = word_ovf; // see (RL10)
      end
      OP_ILWC: begin
        result_nxt = {{32{word_res[31]}}, word_res}; // see (RL9)
        ovf_nxt = word_ovf; // see (RL14)
      end
      OP_ARB: begin
        result_nxt = {{32{right_bytes[31]}}, right_bytes}; // see (RL4)
      end
      OP_ARBR: begin
        result_nxt = {{32{right_bytes[31]}}, right_bytes}; // see (RL4)
      end
      default: begin
        result_nxt = `SSD_RST_RESULT;
      end
    endcase
  end

  wire commit;
  assign commit = ours && !exc_rsvd_nxt && !exc_dis_nxt;

  //////////////////////////////////////////////////////////////////////////
  // Output stage: one cycle from issue to writeback
  always @(posedge CLK) begin
    if (RESET) begin
      RESULT_VALID <= 1'b0;
      RESULT <= `SSD_RST_RESULT;
      EXC_RESERVED <= 1'b0;
      EXC_DISABLED <= 1'b0;
      OVF_SET <= 1'b0;
      LANE_OVF <= `SSD_RST_LANES;
    end else begin
      RESULT_VALID <= commit;
      RESULT <= commit ? result_nxt : `SSD_RST_RESULT;
      EXC_RESERVED <= exc_rsvd_nxt;
      EXC_DISABLED <= exc_dis_nxt;
      // A faulting instruction must leave the flag alone
      OVF_SET <= commit && ovf_nxt;
      LANE_OVF <= commit ? lanes_nxt : `SSD_RST_LANES;
    end
  end

  // Sticky flag: a set arriving with a clear wins, so no event is lost
  always @(posedge CLK) begin
    if (RESET) begin
      OVF_FLAG <= 1'b0;
    end else if (commit && ovf_nxt) begin
      OVF_FLAG <= 1'b1; // see (RL21)
    end else if (OVF_CLEAR) begin
      OVF_FLAG <= 1'b0;
    end
  end

endmodule

// ---- ssd_word_clamp.v ----
// Saturating signed left shift of one 32-bit word
`timescale 1ns/1ps
`include "ssd_defs.vh"
module ssd_word_clamp #(
  parameter W = 32,
  parameter CW = 5
) (
  // Operand and count
  input wire [W-1:0] word_in,
  input wire [CW-1:0] cnt,
  // Result
  output wire [W-1:0] word_out,
  output wire word_ovf
);

  wire [2*W-1:0] wide;
  wire [W:0] top;

  // Sign-extended shift keeps every discarded bit visible
  assign wide = {{W{word_in[W-1]}}, word_in} << cnt; // see (RL7)
  assign top = wide[2*W-1:W-1];
  // Discarded bits plus new top bit must be uniform
  assign word_ovf = ~((&top) | (~|top)); // see (RL13)
  // Clamp direction follows the unshifted sign
  assign word_out = word_ovf ?
    (word_in[W-1] ? `SSD_WORD_MIN : `SSD_WORD_MAX) : wide[W-1:0]; // see (RL12)

endmodule

// ---- tb_ssd_shift_datapath.sv ----
// Self-checking bench for the packed shift datapath
`timescale 1ns/1ps
`include "ssd_defs.vh"
module tb_ssd_shift_datapath;
  reg clk = 1'b0, reset = 1'b1, iv = 1'b0, en = 1'b1, clr = 1'b0;
  reg [31:0] ins = 32'h0;
  reg [63:0] sv = 64'h0, ov = 64'h0;
  wire rv, exr, exd, ovs, ovf;
  wire [63:0] res, wb;
  wire [3:0] lane;
  wire [24:0] ops = {`SSD_SUB_VLB, `SSD_SUB_VLWC, `SSD_SUB_ILWC,
    `SSD_SUB_ARB, `SSD_SUB_ARBR};
  reg [66:0] q[$];
  reg [66:0] e;
  reg ef = 1'b0, pclr = 1'b0;
  reg [15:0] rnd = 16'h8203, r1;
  integer num_errors = 0, n_tests = 0, i;
  always #20 clk = ~clk;
  ssd_shift_datapath ssd_shift_datapath_i (.CLK(clk), .RESET(reset),
    .INSTR_VALID(iv), .INSTR(ins), .SRC_VAL(sv), .OPND_VAL(ov),
    .EXT_ENABLE(en), .OVF_CLEAR(clr), .RESULT_VALID(rv), .RESULT(res),
    .EXC_RESERVED(exr), .EXC_DISABLED(exd), .OVF_SET(ovs),
    .OVF_FLAG(ovf), .LANE_OVF(lane));
  ssd_core_model ssd_core_model_i (.clk(clk), .reset(reset),
    .res_valid(rv), .res(res), .wb_r(wb));
  function [15:0] nx(input [15:0] x);
    nx = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function [31:0] mk(input [4:0] sb, input [4:0] f);
    mk = {`SSD_MAJOR_GROUP, f, 10'h000, sb, `SSD_SHIFT_FUNC};
  endfunction
  // Expected {reserved, disabled, flag set, result} of one issue
  function automatic [66:0] ref_of(input [31:0] n, input [63:0] s,
    input [63:0] o, input g);
    reg [4:0] sb, c;
    reg [31:0] r, x;
    reg [8:0] t;
    reg v;
    integer k;
    begin
      sb = n[10:6];
      v = 1'b0;
      c = sb == `SSD_SUB_ILWC ? n[25:21] : sb == `SSD_SUB_VLWC ? s[4:0] :
        sb == `SSD_SUB_VLB ? {2'h0, s[2:0]} : {2'h0, n[23:21]};
      r = o[31:0];
      if (sb[4]) begin
        x = $signed(o[31:0]) >>> (5'd31 - c);
        v = c != 5'h0 && x != 32'h0 && ~x != 32'h0;
        r = v ? (o[31] ? `SSD_WORD_MIN : `SSD_WORD_MAX) : o[31:0] << c;
      end else for (k = 0; k < 4; k = k + 1) begin
        if (sb == `SSD_SUB_VLB) begin
          v = v | (c != 5'h0 && (o[8*k+:8] >> (7 - c)) != 8'h0);
          r[8*k+:8] = o[8*k+:8] << c;
        end else if (sb[0] && c != 5'h0) begin
          t = ($signed({o[8*k+7], o[8*k+:8]}) >>> (c - 1)) + 1;
          r[8*k+:8] = t[8:1];
        end else r[8*k+:8] = $signed(o[8*k+:8]) >>> c;
      end
      ref_of = (!sb[4] && sb != `SSD_SUB_VLB && n[25:24] != 2'h0) ?
        {3'h4, 64'h0} : !g ? {3'h2, 64'h0} : {2'h0, v, {32{r[31]}}, r};
    end
  endfunction
  task check(input [66:0] seen, input [66:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Issue one word; p says whether an answer is due
  task issue(input [31:0] n, input [63:0] s, input [63:0] o,
    input g, input p);
    begin
      @(posedge clk);
      iv <= 1'b1;
      ins <= n;
      sv <= s;
      ov <= o;
      en <= g;
      if (p) q.push_back(ref_of(n, s, o, g));
    end
  endtask
  // Outputs settled half a cycle after the edge; clear applies one edge on
  always @(negedge clk) begin
    e = 67'h0;
    if (reset) ef = 1'b0;
    else begin
      if (rv === 1'b1 || exr === 1'b1 || exd === 1'b1) begin
        e = q.size() ? q.pop_front() : {3'h7, 64'h0};
        check({exr, exd, ovs, res}, e);
      end
      ef = e[64] | (ef & ~pclr);
      check({66'h0, ovf}, {66'h0, ef});
    end
    pclr = clr;
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    num_errors = num_errors + 1;
    report_and_stop;
  end
  // Corners first, then random back-to-back traffic with random clears
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    issue(mk(`SSD_SUB_VLB, 5'h0), 64'h8, 64'h80FF017F, 1'b1, 1'b1);
    issue(mk(`SSD_SUB_VLWC, 5'h0), 64'h21, 64'h40000000, 1'b1, 1'b1);
    issue(mk(`SSD_SUB_ILWC, 5'h1), 64'h0, 64'h80000001, 1'b1, 1'b1);
    issue(mk(`SSD_SUB_ARBR, 5'h1), 64'h0, 64'h7F80FF01, 1'b1, 1'b1);
    issue(mk(`SSD_SUB_ARB, 5'h9), 64'h0, 64'h1, 1'b1, 1'b1);
    issue(mk(`SSD_SUB_ILWC, 5'h3), 64'h0, 64'h1, 1'b0, 1'b1);
    issue(mk(5'h00, 5'h3), 64'h0, 64'h1, 1'b1, 1'b0);
    issue(mk(`SSD_SUB_VLB, 5'h0) ^ 32'h04000000, 64'h1, 64'h1, 1'b1, 1'b0);
    for (i = 0; i < 300; i = i + 1) begin
      r1 = nx(rnd);
      rnd = nx(r1);
      issue(mk(ops[5*(r1%5)+:5], rnd[4:0] & {~rnd[9:8] | 2'h3 & {2{rnd[7]}}, 3'h7}),
        {rnd, r1, r1, rnd}, {r1, rnd, rnd, r1}, |r1[15:13], 1'b1);
      clr <= rnd[10] & rnd[11];
    end
    @(posedge clk);
    iv <= 1'b0;
    clr <= 1'b0;
    repeat (3) @(posedge clk);
    check(q.size(), 67'h0);
    report_and_stop;
  end
endmodule
